// ===== pled_defines.vh
/*
 * constants for the led indicator control block: register fields, reset
 * value, mode encodings and stretch/blink timing.
 * assumes a 100 mhz system clock.
 */
`ifndef PLED_DEFINES_VH
`define PLED_DEFINES_VH

// ----------------------------------------------------------------------
// register layout
// ----------------------------------------------------------------------
`define PLED_RESET_VAL 16'h3422
`define PLED_RSV_HI_MSB 15
`define PLED_RSV_HI_LSB 14
`define PLED_RSV_ONE_MSB 13
`define PLED_RSV_ONE_LSB 12
`define PLED_FIRST_MSB 11
`define PLED_FIRST_LSB 8
`define PLED_SECOND_MSB 7
`define PLED_SECOND_LSB 4
`define PLED_TSEL_MSB 3
`define PLED_TSEL_LSB 2
`define PLED_STR_EN_BIT 1

// ----------------------------------------------------------------------
// led modes
// ----------------------------------------------------------------------
`define PLED_M_TX 4'h1
`define PLED_M_RX 4'h2
`define PLED_M_COL 4'h3
`define PLED_M_LINK 4'h4
`define PLED_M_DPX 4'h5
`define PLED_M_TXRX 4'h7
`define PLED_M_ON 4'h8
`define PLED_M_OFF 4'h9
`define PLED_M_FAST 4'ha
`define PLED_M_SLOW 4'hb
`define PLED_M_LINK_RX 4'hc
`define PLED_M_LINK_TXRX 4'hd
`define PLED_M_DPX_COL 4'he

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PLED_CLK_HZ 100000000
`define PLED_NORMAL_STRETCH_MS 40
`define PLED_MEDIUM_STRETCH_MS 70
`define PLED_LONG_STRETCH_MS 140
`define PLED_CYC_PER_MS (`PLED_CLK_HZ / 1000)
`define PLED_NORMAL_CYC (`PLED_NORMAL_STRETCH_MS * `PLED_CYC_PER_MS)
`define PLED_MEDIUM_CYC (`PLED_MEDIUM_STRETCH_MS * `PLED_CYC_PER_MS)
`define PLED_LONG_CYC (`PLED_LONG_STRETCH_MS * `PLED_CYC_PER_MS)
`define PLED_FAST_HALF_MS 100
`define PLED_SLOW_HALF_MS 500
`define PLED_FAST_HALF_CYC (`PLED_FAST_HALF_MS * `PLED_CYC_PER_MS)
`define PLED_SLOW_HALF_CYC (`PLED_SLOW_HALF_MS * `PLED_CYC_PER_MS)

`endif

// ===== pled_phy_led_control.v
/*
 * led indicator control: holds the 16-bit led control register and drives
 * two led pins showing link, duplex, activity, fixed or blinking states.
 * assumes the phy management logic supplies wr_en/wr_data, phy status
 * inputs come from sys_clk logic, and led pins are open bidirectional
 * pads sensed once after reset to learn led polarity.
 */
`include "pled_defines.vh"
// Function
// - three stretch durations: normal 40 ms, medium 70 ms, long 140 ms
// - first led field 0111 shows transmit or receive activity, stretched
// - field 0101 shows duplex mode, lit for full duplex
// - field 0100 shows link status, lit while link is up
// - field 0011 shows collision events, stretched
// - field 0010 shows receive activity, stretched
// - second field 1100 shows link, blinks on receive, always stretched
// - sense each led pin polarity at reset, drive matching polarity after
module pled_phy_led_control #(
    parameter NORMAL_CYC = `PLED_NORMAL_CYC,
    parameter MEDIUM_CYC = `PLED_MEDIUM_CYC,
    parameter LONG_CYC = `PLED_LONG_CYC,
    parameter FAST_HALF_CYC = `PLED_FAST_HALF_CYC,
    parameter SLOW_HALF_CYC = `PLED_SLOW_HALF_CYC
) (
    input wire sys_clk,
    input wire srst,
    input wire clk_en,
    input wire wr_en,
    input wire [15:0] wr_data,
    output reg [15:0] led_indicator_control,
    input wire link_up,
    input wire full_duplex,
    input wire tx_event,
    input wire rx_event,
    input wire col_event,
    input wire first_led_pin_in,
    output reg first_led_pin_out,
    output reg first_led_pin_oe,
    input wire second_led_pin_in,
    output reg second_led_pin_out,
    output reg second_led_pin_oe
);

    // ------------------------------------------------------------------
    // register
    // ------------------------------------------------------------------
    // reserved bits are stored as written; software keeps 00 and 11 there
    always @(posedge sys_clk)
    begin
        if (srst)
            led_indicator_control <= `PLED_RESET_VAL;
        else if (clk_en && wr_en)
            led_indicator_control <= wr_data;
    end

    wire [3:0] first_led_config = led_indicator_control[`PLED_FIRST_MSB:`PLED_FIRST_LSB];
    wire [3:0] second_led_config = led_indicator_control[`PLED_SECOND_MSB:`PLED_SECOND_LSB];
    wire [1:0] stretch_time_select = led_indicator_control[`PLED_TSEL_MSB:`PLED_TSEL_LSB];
    wire stretch_enable = led_indicator_control[`PLED_STR_EN_BIT];

    // ------------------------------------------------------------------
    // polarity sensing
    // ------------------------------------------------------------------
    // pins released for a few cycles after reset; the idle pull level tells
    // whether the led sits to ground (pin sources) or to supply (pin sinks)
    reg [2:0] sync_a_r;
    reg [2:0] sync_b_r;
    reg [3:0] sense_cnt_r;
    reg sensed_r;
    reg act_high_a_r;
    reg act_high_b_r;

    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
            sense_cnt_r <= 4'h0;
            sensed_r <= 1'b0;
            act_high_a_r <= 1'b1;
            act_high_b_r <= 1'b1;
        end
        else if (clk_en)
        begin
            sync_a_r <= {sync_a_r[1:0], first_led_pin_in};
            sync_b_r <= {sync_b_r[1:0], second_led_pin_in};
            if (!sensed_r)
            begin
                sense_cnt_r <= sense_cnt_r + 4'h1;
                // sample only when the last two stages agree
                if (sense_cnt_r == 4'hf && sync_a_r[2] == sync_a_r[1]
                    && sync_b_r[2] == sync_b_r[1])
                begin
                    act_high_a_r <= ~sync_a_r[2];
                    act_high_b_r <= ~sync_b_r[2];
                    sensed_r <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // event stretching, one stretcher per led
    // ------------------------------------------------------------------
    reg [31:0] stretch_len;
    always @*
    begin
        case (stretch_time_select)
            2'h1: stretch_len = MEDIUM_CYC;
            2'h2: stretch_len = LONG_CYC;
            default: stretch_len = NORMAL_CYC;
        endcase
    end

    // ------------------------------------------------------------------
    // blink timebases
    // ------------------------------------------------------------------
    reg [31:0] fast_cnt_r;
    reg [31:0] slow_cnt_r;
    reg fast_ph_r;
    reg slow_ph_r;
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            fast_cnt_r <= 32'h0;
            slow_cnt_r <= 32'h0;
            fast_ph_r <= 1'b0;
            slow_ph_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fast_cnt_r >= FAST_HALF_CYC - 1)
            begin
                fast_cnt_r <= 32'h0;
                fast_ph_r <= ~fast_ph_r;
            end
            else
                fast_cnt_r <= fast_cnt_r + 32'h1;
            if (slow_cnt_r >= SLOW_HALF_CYC - 1)
            begin
                slow_cnt_r <= 32'h0;
                slow_ph_r <= ~slow_ph_r;
            end
            else
                slow_cnt_r <= slow_cnt_r + 32'h1;
        end
    end

    wire [7:0] cfgs = {first_led_config, second_led_config};
    wire [1:0] led_lit;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_led
            wire [3:0] cfg = cfgs[7 - 4 * g -: 4];
            reg ev;
            reg always_str;
            reg lit;
            reg [31:0] cnt_r;
            always @*
            begin
                always_str = 1'b0;
                case (cfg)
                    `PLED_M_TX: ev = tx_event;
                    `PLED_M_RX: ev = rx_event;
                    `PLED_M_COL: ev = col_event;
                    `PLED_M_TXRX: ev = tx_event | rx_event;
                    `PLED_M_LINK_RX:
                    begin
                        ev = rx_event;
                        always_str = 1'b1;
                    end
                    `PLED_M_LINK_TXRX:
                    begin
                        ev = tx_event | rx_event;
                        always_str = 1'b1;
                    end
                    `PLED_M_DPX_COL:
                    begin
                        ev = col_event;
                        always_str = 1'b1;
                    end
                    default: ev = 1'b0;
                endcase
            end
            // counter restarts on every event so bursts stay lit throughout
            always @(posedge sys_clk)
            begin
                if (srst)
                    cnt_r <= 32'h0;
                else if (clk_en)
                begin
                    if (ev)
                        cnt_r <= stretch_len;
                    else if (cnt_r != 32'h0)
                        cnt_r <= cnt_r - 32'h1;
                end
            end
            wire str_on = (stretch_enable | always_str) ? (ev | (cnt_r != 32'h0)) : ev;
            always @*
            begin
                case (cfg)
                    `PLED_M_LINK: lit = link_up;
                    `PLED_M_DPX: lit = full_duplex;
                    `PLED_M_ON: lit = 1'b1;
                    `PLED_M_OFF: lit = 1'b0;
                    `PLED_M_FAST: lit = fast_ph_r;
                    `PLED_M_SLOW: lit = slow_ph_r;
                    // link shown steady, activity blinks it off briefly
                    `PLED_M_LINK_RX: lit = link_up & ~str_on;
                    `PLED_M_LINK_TXRX: lit = link_up & ~str_on;
                    `PLED_M_DPX_COL: lit = full_duplex ^ str_on;
                    `PLED_M_TX, `PLED_M_RX, `PLED_M_COL, `PLED_M_TXRX: lit = str_on;
                    default: lit = 1'b0;
                endcase
            end
            assign led_lit[1 - g] = lit;
        end
    endgenerate

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            first_led_pin_out <= 1'b0;
            first_led_pin_oe <= 1'b0;
            second_led_pin_out <= 1'b0;
            second_led_pin_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            first_led_pin_oe <= sensed_r;
            second_led_pin_oe <= sensed_r;
            first_led_pin_out <= ~(led_lit[1] ^ act_high_a_r);
            second_led_pin_out <= ~(led_lit[0] ^ act_high_b_r);
        end
    end

endmodule // pled_phy_led_control

// ===== pled_led_model.sv
/* two indicator leds on the block's pads: the first lights on sourced
   current (pull-down on its pad), the second on sunk current (pull-up).
   assumes the pad drive and enable signals of the led control block. */
module pled_led_model (
    input wire first_out,
    input wire first_oe,
    input wire second_out,
    input wire second_oe,
    output wire first_pad,
    output wire second_pad,
    output wire first_lit,
    output wire second_lit
);
    // ------------------------------------------------------------
    // pads and lamps
    // ------------------------------------------------------------
    // a released pad falls to its pull level, which keeps its lamp dark
    assign first_pad = first_oe ? first_out : 1'b0;
    assign second_pad = second_oe ? second_out : 1'b1;
    assign first_lit = first_pad;
    assign second_lit = ~second_pad;
endmodule // pled_led_model

// ===== pled_chk_assertions.sv
/* concurrent checks on the led control block ports.
   assumes checks other than the three reset checks pause while clk_en is low, since all state freezes then. */
module pled_chk (
    input wire sys_clk,
    input wire srst,
    input wire clk_en,
    input wire wr_en,
    input wire [15:0] wr_data,
    input wire [15:0] led_indicator_control,
    input wire link_up,
    input wire full_duplex,
    input wire rx_event,
    input wire first_led_pin_out,
    input wire first_led_pin_oe,
    input wire second_led_pin_out,
    input wire second_led_pin_oe
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst || !clk_en);
    wire [3:0] fa = led_indicator_control[11:8];
    wire [3:0] fb = led_indicator_control[7:4];
    wire ob = second_led_pin_oe;
    reset_value_a: assert property (disable iff (1'b0) srst |=> led_indicator_control == 16'h3422)
        else $error("reset value wrong");
    write_store_a: assert property (wr_en |=> led_indicator_control == $past(wr_data))
        else $error("write not stored");
    reg_hold_a: assert property (!wr_en |=> $stable(led_indicator_control))
        else $error("register changed without write");
    pins_reset_a: assert property (disable iff (1'b0) srst |=> !first_led_pin_oe && !ob)
        else $error("pad driven in reset");
    release_wait_a: assert property (disable iff (1'b0) $fell(srst) |-> !first_led_pin_oe [*8])
        else $error("pad driven before sensing");
    link_follow_a: assert property (fa == 4'h4 && $stable(fa) && first_led_pin_oe
        && $past(first_led_pin_oe) && $changed(link_up) |=> $changed(first_led_pin_out))
        else $error("link lamp not following");
    dpx_follow_a: assert property (fb == 4'h5 && $stable(fb) && ob && $past(ob)
        && $changed(full_duplex) |=> $changed(second_led_pin_out))
        else $error("duplex lamp not following");
    rx_raw_a: assert property (fb == 4'h2 && !led_indicator_control[1]
        && $stable(led_indicator_control) && ob && $past(ob) && $changed(rx_event)
        |=> $changed(second_led_pin_out)) else $error("raw rx lamp wrong");
    rx_stretch_a: assert property (fb == 4'h2 && led_indicator_control[1] && ob
        && $fell(rx_event) |=> $stable(second_led_pin_out) [*8])
        else $error("rx stretch cut short");
endmodule // pled_chk
bind pled_phy_led_control pled_chk chk_u (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .wr_en(wr_en),
    .wr_data(wr_data), .led_indicator_control(led_indicator_control), .link_up(link_up),
    .full_duplex(full_duplex), .rx_event(rx_event), .first_led_pin_out(first_led_pin_out),
    .first_led_pin_oe(first_led_pin_oe), .second_led_pin_out(second_led_pin_out),
    .second_led_pin_oe(second_led_pin_oe));

// ===== tb.sv
/* self-checking bench for the led control block with two lamps attached.
   assumes shortened stretch counts 20/35/70 and blink half periods 8/16. */
`include "pled_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    logic sys_clk = 0, srst = 1, wr_en = 0, link_up = 0, full_duplex = 0, clk_en = 1;
    logic [2:0] evt = 3'b000;
    logic [15:0] wr_data = 16'h0000;
    wire [15:0] lic;
    wire fo, foe, so, soe, fpad, spad, flit, slit;
    int n_mismatch = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    pled_phy_led_control #(.NORMAL_CYC(20), .MEDIUM_CYC(35), .LONG_CYC(70), .FAST_HALF_CYC(8),
        .SLOW_HALF_CYC(16)) dut_u (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .wr_en(wr_en), .wr_data(wr_data), .led_indicator_control(lic), .link_up(link_up),
        .full_duplex(full_duplex), .tx_event(evt[2]), .rx_event(evt[0]), .col_event(evt[1]),
        .first_led_pin_in(fpad), .first_led_pin_out(fo), .first_led_pin_oe(foe),
        .second_led_pin_in(spad), .second_led_pin_out(so), .second_led_pin_oe(soe));
    pled_led_model led_u (.first_out(fo), .first_oe(foe), .second_out(so), .second_oe(soe),
        .first_pad(fpad), .second_pad(spad), .first_lit(flit), .second_lit(slit));
    task stop_test;
        $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task wr(input [3:0] a, input [3:0] b, input [1:0] sel, input en);
        wr_data = {2'b00, 2'b11, a, b, sel, en, 1'b0};
        wr_en = 1;
        tick(1);
        wr_en = 0;
        tick(1);
        chk(lic, wr_data);
    endtask
    // one event pulse, then lit while stretching, dark after it runs out
    task act(input [2:0] ev, input led, input int len, input en);
        evt = ev;
        tick(1);
        chk(led ? slit : flit, 1'b1);
        evt = 3'b000;
        tick(en ? len - 3 : 2);
        chk(led ? slit : flit, en);
        tick(en ? 7 : 1);
        chk(led ? slit : flit, 1'b0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk(lic, 16'h3422);
        tick(20);
        chk({foe, soe}, 2'b11);
        chk({flit, slit}, 2'b00);
        link_up = 1;
        tick(2);
        chk(flit, 1'b1);
        link_up = 0;
        tick(2);
        chk(flit, 1'b0);
        act(3'b001, 1, 20, 1);
    endtask
    task t_stretch;
        wr(4'h4, `PLED_M_RX, 2'b01, 1);
        act(3'b001, 1, 35, 1);
        wr(4'h4, `PLED_M_RX, 2'b10, 1);
        act(3'b001, 1, 70, 1);
        wr(4'h4, `PLED_M_RX, 2'b11, 1);
        act(3'b001, 1, 20, 1);
        wr(4'h4, `PLED_M_RX, 2'b00, 0);
        act(3'b001, 1, 0, 0);
    endtask
    task t_modes;
        wr(4'h4, `PLED_M_DPX, 2'b00, 1);
        full_duplex = 1;
        tick(2);
        chk(slit, 1'b1);
        full_duplex = 0;
        tick(2);
        chk(slit, 1'b0);
        wr(`PLED_M_TXRX, `PLED_M_RX, 2'b00, 1);
        act(3'b100, 0, 20, 1);
        act(3'b001, 0, 20, 1);
        wr(`PLED_M_COL, `PLED_M_RX, 2'b00, 1);
        act(3'b010, 0, 20, 1);
        wr(4'h4, `PLED_M_LINK_RX, 2'b00, 0);
        link_up = 1;
        tick(2);
        chk(slit, 1'b1);
        evt = 3'b001;
        tick(1);
        evt = 3'b000;
        tick(10);
        chk(slit, 1'b0);
        tick(20);
        chk(slit, 1'b1);
    endtask
    // enable low must hold the lamp state even though link drops
    task t_freeze;
        clk_en = 0;
        link_up = 0;
        tick(3);
        chk(flit, 1'b1);
        clk_en = 1;
        tick(2);
        chk(flit, 1'b0);
    endtask
    // a second reset mid-run restores defaults and senses polarity again
    task t_rereset;
        wr(`PLED_M_ON, `PLED_M_ON, 2'b01, 0);
        tick(1);
        chk({flit, slit}, 2'b11);
        srst = 1;
        tick(2);
        srst = 0;
        chk(lic, `PLED_RESET_VAL);
        chk({foe, soe}, 2'b00);
        tick(20);
        chk({foe, soe}, 2'b11);
        chk({flit, slit}, 2'b00);
    endtask
    task t_other;
        logic f0, s0;
        wr(`PLED_M_TX, `PLED_M_DPX_COL, 2'b00, 0);
        act(3'b100, 0, 0, 0);
        full_duplex = 1;
        tick(2);
        chk(slit, 1'b1);
        evt = 3'b010;
        tick(1);
        evt = 3'b000;
        tick(10);
        chk(slit, 1'b0);
        tick(20);
        chk(slit, 1'b1);
        full_duplex = 0;
        wr(`PLED_M_FAST, `PLED_M_SLOW, 2'b00, 1);
        f0 = flit;
        s0 = slit;
        tick(8);
        chk(flit, !f0);
        tick(8);
        chk({flit, slit}, {f0, !s0});
    endtask
    initial
    begin
        tick(2);
        srst = 0;
        t_reset;
        t_stretch;
        t_modes;
        t_freeze;
        t_rereset;
        t_other;
        stop_test;
    end
    initial
    begin
        #50000;
        n_mismatch++;
        stop_test;
    end
endmodule // tb
